// File: design/eee_lpi_config_control.sv
// Purpose: EEE configuration registers and the controls they steer
// Assumes: one 125 MHz clock, synchronous active-high reset, inputs synchronous
// Notes:   strap is sampled by a clocked process while reset is held
module eee_lpi_config_control
   import eee_cfg_pkg::*;
(
   // clock and reset
   input  wire logic                        CLK_IN,
   input  wire logic                        SYS_RST_IN,
   // strap
   input  wire logic                        EEE_STRAP_IN,
   // register port
   input  wire logic [eee_cfg_pkg::ADDR_W-1:0] ADDR_IN,
   input  wire logic [eee_cfg_pkg::DATA_W-1:0] WDATA_IN,
   input  wire logic                        WR_IN,
   input  wire logic                        RD_IN,
   output logic      [eee_cfg_pkg::DATA_W-1:0] RDATA_OUT,
   // mac side and mmd view
   input  wire eee_cfg_pkg::mac_pins_t      MAC_PINS_IN,
   input  wire eee_cfg_pkg::mmd_view_t      MMD_IN,
   // controls
   output logic                             LPI_REQ_OUT,
   output logic                             ADV_EEE_100_OUT,
   output logic                             LP_EEE_100_OUT,
   output logic                             NP_RX_EN_OUT,
   output logic                             RX_ANALOG_OFF_OUT
);
   import eee_cfg_pkg::*;

   // ******************************
   // registers
   // ******************************
   logic [15:0] lpi_pin;
   logic [15:0] neg;
   logic [15:0] next_lpi_pin;
   logic [15:0] next_neg;
   logic [15:0] next_rdata;
   logic        next_lpi_req;
   logic        next_adv;
   logic        next_lp;
   logic        next_np_en;
   logic        next_rx_off;
   logic        req_src;
   logic        eee_en;
   logic        bypass;
   logic        wr_lpi_pin;
   logic        wr_neg;
   logic        rd_lpi_pin;
   logic        rd_neg;
   logic        sel_pin;

   function automatic logic pick_pin(input logic [1:0] sel, input mac_pins_t p);
      logic r;
      r = 1'b0;
      case (pin_sel_t'(sel))
         PIN_INTPD: r = p.interrupt_powerdown_pin;
         PIN_COLGP: r = p.col_gpio_pin;
         default:   r = 1'b0;
      endcase
      return r;
   endfunction

   // one register strobe hit; shared by the write and the read decode
   function automatic logic reg_hit(input logic              strobe,
                                    input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] ofs);
      return strobe && (addr == ofs);
   endfunction

   // ******************************
   // address decode
   // ******************************
   always_comb begin
      wr_lpi_pin = 1'b0;
      wr_neg     = 1'b0;
      if (reg_hit(WR_IN, ADDR_IN, OFS_LPI_PIN)) begin
         wr_lpi_pin = 1'b1;
      end else if (reg_hit(WR_IN, ADDR_IN, OFS_NEG)) begin
         wr_neg = 1'b1;
      end
   end

   always_comb begin
      rd_lpi_pin = 1'b0;
      rd_neg     = 1'b0;
      if (reg_hit(RD_IN, ADDR_IN, OFS_LPI_PIN)) begin
         rd_lpi_pin = 1'b1;
      end else if (reg_hit(RD_IN, ADDR_IN, OFS_NEG)) begin
         rd_neg = 1'b1;
      end
   end

   // ******************************
   // configuration registers
   // ******************************
   always_comb begin
      next_lpi_pin = lpi_pin;
      next_neg     = neg;
      if (SYS_RST_IN) begin
         next_lpi_pin         = LPI_PIN_RST;
         next_neg             = NEG_RST;
         next_neg[BIT_EEE_EN] = EEE_STRAP_IN;
      end else if (wr_lpi_pin) begin
         // reserved bits here are read-only and keep their defaults
         next_lpi_pin = (lpi_pin & ~LPI_PIN_RW) | (WDATA_IN & LPI_PIN_RW);
      end else if (wr_neg) begin
         // every bit is writable, so only software keeps the reserved field
         next_neg = WDATA_IN;
      end
   end

   always_ff @(posedge CLK_IN) begin
      lpi_pin <= next_lpi_pin;
      neg     <= next_neg;
   end

   // ******************************
   // read data
   // ******************************
   // zero except in the single cycle after a read strobe
   always_comb begin
      next_rdata = '0;
      if (SYS_RST_IN) begin
         next_rdata = '0;
      end else if (rd_lpi_pin) begin
         next_rdata = lpi_pin;
      end else if (rd_neg) begin
         next_rdata = neg;
      end
   end

   always_ff @(posedge CLK_IN) begin
      RDATA_OUT <= next_rdata;
   end

   // ******************************
   // register fields in use
   // ******************************
   always_comb begin
      eee_en = neg[BIT_EEE_EN];
      bypass = neg[BIT_BYPASS];
   end

   // ******************************
   // lpi request
   // ******************************
   always_comb begin
      sel_pin      = pick_pin(lpi_pin[PSEL_HI:PSEL_LO], MAC_PINS_IN);
      req_src      = MAC_PINS_IN.tx_er | sel_pin;
      next_lpi_req = 1'b0;
      if (!SYS_RST_IN) begin
         next_lpi_req = lpi_pin[BIT_TXER_LPI] & eee_en & req_src;
      end
   end

   always_ff @(posedge CLK_IN) begin
      LPI_REQ_OUT <= next_lpi_req;
   end

   // ******************************
   // negotiation abilities
   // ******************************
   always_comb begin
      next_adv = 1'b0;
      next_lp  = 1'b0;
      if (SYS_RST_IN) begin
         next_adv = 1'b0;
         next_lp  = 1'b0;
      end else if (bypass) begin
         next_adv = eee_en;
         next_lp  = eee_en;
      end else begin
         // with the enable bit clear the mmd abilities are ignored
         next_adv = eee_en & MMD_IN.mmd3_cap_100 & MMD_IN.mmd7_adv_100;
         next_lp  = eee_en & MMD_IN.mmd7_lp_100;
      end
   end

   always_ff @(posedge CLK_IN) begin
      ADV_EEE_100_OUT <= next_adv;
      LP_EEE_100_OUT  <= next_lp;
   end

   // ******************************
   // next page and receive path
   // ******************************
   always_comb begin
      next_np_en  = 1'b0;
      next_rx_off = 1'b0;
      if (!SYS_RST_IN) begin
         next_np_en  = eee_en & ~neg[BIT_NP_DIS];
         next_rx_off = neg[BIT_RX_SHUT] & MMD_IN.lpi_quiet;
      end
   end

   always_ff @(posedge CLK_IN) begin
      NP_RX_EN_OUT      <= next_np_en;
      RX_ANALOG_OFF_OUT <= next_rx_off;
   end

   // ******************************
   // checks
   // ******************************
   a_lpi_req_gate: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      !$past(lpi_pin[BIT_TXER_LPI]) |-> !LPI_REQ_OUT)
      else $error("lpi request without enable");
   a_pin_none: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      (lpi_pin[BIT_TXER_LPI] && eee_en && !MAC_PINS_IN.tx_er
       && (lpi_pin[PSEL_HI] == lpi_pin[PSEL_LO])) |=> !LPI_REQ_OUT)
      else $error("lpi request from unselected pin");
   a_pin_intpd: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      (lpi_pin[BIT_TXER_LPI] && eee_en && lpi_pin[PSEL_HI:PSEL_LO] == PIN_INTPD
       && MAC_PINS_IN.interrupt_powerdown_pin) |=> LPI_REQ_OUT)
      else $error("interrupt pin request lost");
   a_bypass_adv: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      bypass |=> (ADV_EEE_100_OUT == $past(eee_en)))
      else $error("bypass advertisement wrong");
   a_np_disable: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      neg[BIT_NP_DIS] |=> !NP_RX_EN_OUT)
      else $error("next page enabled while disabled");
   a_rx_shut: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      (MMD_IN.lpi_quiet && neg[BIT_RX_SHUT]) |=> RX_ANALOG_OFF_OUT)
      else $error("rx path not shut in quiet");
   a_eee_off: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      !eee_en |=> (!ADV_EEE_100_OUT && !LP_EEE_100_OUT))
      else $error("eee negotiated while disabled");
   a_reset_vals: assert property (@(posedge CLK_IN)
      $past(SYS_RST_IN) |-> (neg[BIT_BYPASS] && neg[BIT_RX_SHUT] && !neg[BIT_NP_DIS]
       && neg[BIT_EEE_EN] == $past(EEE_STRAP_IN)))
      else $error("reset values wrong");
   a_adv_mmd7: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      (!bypass && eee_en && !MMD_IN.mmd7_adv_100) |=> !ADV_EEE_100_OUT)
      else $error("advertised without mmd7 bit");

   // ******************************
   // contract checks
   // ******************************
   a_txer_request: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      (lpi_pin[BIT_TXER_LPI] && eee_en && MAC_PINS_IN.tx_er) |=> LPI_REQ_OUT)
      else $error("transmit error request lost");
   a_pin_colgp: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      (lpi_pin[BIT_TXER_LPI] && eee_en && lpi_pin[PSEL_HI:PSEL_LO] == PIN_COLGP
       && MAC_PINS_IN.col_gpio_pin) |=> LPI_REQ_OUT)
      else $error("collision pin request lost");
   a_intpd_only: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      (lpi_pin[PSEL_HI:PSEL_LO] == PIN_INTPD && !MAC_PINS_IN.tx_er
       && !MAC_PINS_IN.interrupt_powerdown_pin) |=> !LPI_REQ_OUT)
      else $error("request from pin not selected");
   a_bypass_lp: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      bypass |=> (LP_EEE_100_OUT == $past(eee_en)))
      else $error("bypass partner ability wrong");
   a_mmd_adv: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      (!bypass && eee_en && MMD_IN.mmd3_cap_100 && MMD_IN.mmd7_adv_100)
       |=> ADV_EEE_100_OUT)
      else $error("mmd advertisement lost");
   a_mmd_lp: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      !bypass |=> (LP_EEE_100_OUT == $past(eee_en && MMD_IN.mmd7_lp_100)))
      else $error("partner ability wrong");
   a_np_enable: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      (eee_en && !neg[BIT_NP_DIS]) |=> NP_RX_EN_OUT)
      else $error("next page reception not enabled");
   a_rx_active: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      !neg[BIT_RX_SHUT] |=> !RX_ANALOG_OFF_OUT)
      else $error("rx path shut while kept active");
   a_ro_bits_held: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      (lpi_pin & ~LPI_PIN_RW) == (LPI_PIN_RST & ~LPI_PIN_RW))
      else $error("read-only bits changed");
   a_neg_write: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      wr_neg |=> (neg == $past(WDATA_IN)))
      else $error("negotiation write lost");
   a_pin_write: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      wr_lpi_pin |=> ((lpi_pin & LPI_PIN_RW) == ($past(WDATA_IN) & LPI_PIN_RW)))
      else $error("lpi pin write lost");
   a_rdata_lpi: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      rd_lpi_pin |=> (RDATA_OUT == $past(lpi_pin)))
      else $error("lpi pin read data wrong");
   a_rdata_neg: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      rd_neg |=> (RDATA_OUT == $past(neg)))
      else $error("negotiation read data wrong");
   a_rdata_idle: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      !RD_IN |=> (RDATA_OUT == '0))
      else $error("read data without strobe");
   a_unmapped_wr: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      (WR_IN && !wr_lpi_pin && !wr_neg) |=> ($stable(neg) && $stable(lpi_pin)))
      else $error("unmapped write changed a register");
   a_out_reset: assert property (@(posedge CLK_IN)
      SYS_RST_IN |=> (!LPI_REQ_OUT && !ADV_EEE_100_OUT && !LP_EEE_100_OUT
       && !NP_RX_EN_OUT && !RX_ANALOG_OFF_OUT && RDATA_OUT == '0))
      else $error("outputs not cleared by reset");

endmodule

// File: design/eee_cfg_pkg.sv
// Purpose: constants and carriers for the EEE configuration block
// Assumes: 16-bit register bank on a plain strobe port
// Notes:   offsets are register addresses on the strobe port
package eee_cfg_pkg;

   localparam int          ADDR_W = 16;
   localparam int          DATA_W = 16;

   // ******************************
   // register offsets
   // ******************************
   localparam logic [15:0] OFS_LPI_PIN = 16'h04d0;
   localparam logic [15:0] OFS_NEG     = 16'h04d1;

   // ******************************
   // first register: lpi pin
   // ******************************
   localparam int          BIT_TXER_LPI  = 14;
   localparam int          PSEL_HI       = 6;
   localparam int          PSEL_LO       = 5;
   localparam logic [15:0] LPI_PIN_RW    = 16'h4060;
   localparam logic [15:0] LPI_PIN_RST   = 16'h0302;

   // ******************************
   // second register: negotiation
   // ******************************
   localparam int          BIT_BYPASS  = 3;
   localparam int          BIT_NP_DIS  = 2;
   localparam int          BIT_RX_SHUT = 1;
   localparam int          BIT_EEE_EN  = 0;
   localparam logic [15:0] NEG_RST     = 16'h018a;

   // ******************************
   // mmd ability bits
   // ******************************
   localparam int          BIT_ABIL_100 = 1;

   // pin select codes
   typedef enum logic [1:0] {
      PIN_NONE0 = 2'b00,
      PIN_INTPD = 2'b01,
      PIN_COLGP = 2'b10,
      PIN_NONE1 = 2'b11
   } pin_sel_t;

   // signals seen on the mac side
   typedef struct packed {
      logic tx_er;
      logic interrupt_powerdown_pin;
      logic col_gpio_pin;
   } mac_pins_t;

   // abilities from the mmd registers
   typedef struct packed {
      logic mmd3_cap_100;
      logic mmd7_adv_100;
      logic mmd7_lp_100;
      logic lpi_quiet;
   } mmd_view_t;

endpackage

// File: verification/mac_model.sv
// Purpose: MAC side model driving transmit error and the two selectable pins
// Assumes: pins are levels launched from the MAC clock edge
// Notes:   the bench names the level of each pin, tx_er first
module mac_model
   import eee_cfg_pkg::*;
(
   // clock
   input  wire logic              CLK_IN,
   // requested levels
   input  wire logic [2:0]        LEVELS_IN,
   // pins towards the device
   output eee_cfg_pkg::mac_pins_t PINS_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge CLK_IN) begin
      PINS_OUT <= LEVELS_IN;
   end
endmodule

// File: verification/testbench.sv
// Purpose: register and control checks of the EEE configuration block
// Assumes: strap high through the first reset, low through a second one
// Notes:   expected controls are worked out per config for all input levels
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import eee_cfg_pkg::*;
   logic        clk, rst, strap, wr_en, rd_en;
   logic [15:0] addr, wdata, rdata, d, e, outs;
   logic [2:0]  lv;
   mac_pins_t   pins;
   mmd_view_t   mmd;
   logic        lpi, adv, lp, np, off;
   int          n_fail = 0;
   int          samples_checked = 0;
   logic [15:0] cfg_a [5] = '{16'h4000, 16'h4020, 16'h4040, 16'h4060, 16'h0020};
   logic [15:0] cfg_b [5] = '{16'h018f, 16'h0187, 16'h018d, 16'h0183, 16'h018e};
   // ******************************
   // instances
   // ******************************
   mac_model u_mac (.CLK_IN(clk), .LEVELS_IN(lv), .PINS_OUT(pins));
   eee_lpi_config_control u_dut (.CLK_IN(clk), .SYS_RST_IN(rst), .EEE_STRAP_IN(strap),
      .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr_en), .RD_IN(rd_en), .RDATA_OUT(rdata),
      .MAC_PINS_IN(pins), .MMD_IN(mmd), .LPI_REQ_OUT(lpi), .ADV_EEE_100_OUT(adv),
      .LP_EEE_100_OUT(lp), .NP_RX_EN_OUT(np), .RX_ANALOG_OFF_OUT(off));
   assign outs = {11'h0, lpi, adv, lp, np, off};
   always #4 clk = ~clk;
   // ******************************
   // tasks
   // ******************************
   function automatic logic [15:0] expect_out(input logic [15:0] a, b);
      logic pin;
      pin = (a[6:5] == 2'b01) ? pins.interrupt_powerdown_pin :
            (a[6:5] == 2'b10) ? pins.col_gpio_pin : 1'b0;
      return {11'h0, a[14] & b[0] & (pins.tx_er | pin),
              b[3] ? b[0] : b[0] & mmd.mmd3_cap_100 & mmd.mmd7_adv_100,
              b[3] ? b[0] : b[0] & mmd.mmd7_lp_100, b[0] & ~b[2], b[1] & mmd.lpi_quiet};
   endfunction
   task automatic check(input string name, input logic [15:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic reg_wr(input logic [15:0] a, v);
      @(posedge clk);
      addr <= a; wdata <= v; wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   task automatic reg_rd(input logic [15:0] a, output logic [15:0] v);
      @(posedge clk);
      addr <= a; rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic end_sim;
      $display("checks %0d failures %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ******************************
   // tests
   // ******************************
   initial begin
      repeat (12000) @(posedge clk);
      n_fail++;
      end_sim();
   end
   initial begin
      clk = 0; rst = 1; strap = 1; addr = '0; wdata = '0; wr_en = 0; rd_en = 0;
      lv = '0; mmd = '0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      #1 check("reset controls", outs, expect_out(LPI_PIN_RST, NEG_RST | 16'h0001));
      reg_rd(OFS_LPI_PIN, d);
      check("lpi_pin reset", d, LPI_PIN_RST);
      reg_rd(OFS_NEG, d);
      check("negotiation reset", d, NEG_RST | 16'h0001);
      reg_rd(16'h04d2, d);
      check("unmapped read", d, 16'h0000);
      reg_wr(16'h04d2, 16'h0000);
      reg_rd(OFS_NEG, d);
      check("unmapped write", d, NEG_RST | 16'h0001);
      reg_wr(OFS_LPI_PIN, 16'hffff);
      reg_rd(OFS_LPI_PIN, d);
      check("lpi_pin writable", d, LPI_PIN_RST | LPI_PIN_RW);
      reg_wr(OFS_LPI_PIN, 16'h0000);
      reg_rd(OFS_LPI_PIN, d);
      check("lpi_pin reserved", d, LPI_PIN_RST);
      for (int c = 0; c < 5; c++) begin
         reg_wr(OFS_LPI_PIN, cfg_a[c]);
         reg_wr(OFS_NEG, cfg_b[c]);
         reg_rd(OFS_NEG, d);
         check("negotiation", d, cfg_b[c]);
         for (int v = 0; v < 128; v++) begin
            @(posedge clk);
            lv <= v[6:4];
            mmd <= v[3:0];
            repeat (3) @(posedge clk);
            #1 e = expect_out(cfg_a[c], cfg_b[c]);
            check("controls", outs, e);
         end
      end
      // second reset in mid-run, strap now low
      @(posedge clk);
      strap <= 1'b0;
      rst   <= 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      #1 check("strap low controls", outs, expect_out(LPI_PIN_RST, NEG_RST));
      reg_rd(OFS_NEG, d);
      check("strap low reset", d, NEG_RST);
      reg_rd(OFS_LPI_PIN, d);
      check("lpi_pin second reset", d, LPI_PIN_RST);
      end_sim();
   end
endmodule
